// >>> core/cycle_qualifier.sv
/*
 * Counts oscillator cycles while a level holds and reports once the count passes a limit.
 * Assumes tick is a one-clock pulse per oscillator cycle.
 */
`timescale 1ns/100ps
`default_nettype none
module cycle_qualifier (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic tick,
    input wire logic level,
    output logic ok
);
    import prot_pkg::*;

    typedef struct packed {
        logic [10:0] cnt;
    } qual_state_t;

    qual_state_t s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        if (!level) begin
            s_next.cnt = '0;
        end else if (tick && s_reg.cnt <= PFC_QUAL_CYCLES) begin
            s_next.cnt = s_reg.cnt + 11'h001;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    // More than the limit, so a count equal to it is not enough
    assign ok = level && (s_reg.cnt > PFC_QUAL_CYCLES);
endmodule // cycle_qualifier
`default_nettype wire

// >>> core/prot_pkg.sv
/*
 * Constants, field positions and state encodings of the converter protection sequencer.
 * Assumes a 40 MHz clock and an APB master with 32-bit data.
 */
package prot_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int OVP_DELAY_NS = 2000;
    localparam int OVP_WIDTH_NS = 500;
    localparam int OVP_DELAY_CYC = (OVP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OVP_WIDTH_CYC = OVP_WIDTH_NS / CLK_PERIOD_NS;
    localparam logic [7:0] OVP_START = 8'(OVP_DELAY_CYC);
    localparam logic [7:0] OVP_END = 8'(OVP_DELAY_CYC + OVP_WIDTH_CYC);
    localparam logic [10:0] PFC_QUAL_CYCLES = 11'h400;
    localparam logic [2:0] OVP_LAST_COUNT = 3'h3;

    localparam int NIN = 18;
    localparam int I_SEVERE = 0;
    localparam int I_OFF_QR = 1;
    localparam int I_OFF_FF = 2;
    localparam int I_COMP_ON = 3;
    localparam int I_BURST = 4;
    localparam int I_SAT = 5;
    localparam int I_DIS = 6;
    localparam int I_SS_2V = 7;
    localparam int I_SS_5V = 8;
    localparam int I_SS_LATCH = 9;
    localparam int I_OVP = 10;
    localparam int I_VFF_LATCH = 11;
    localparam int I_MAINS_FAIL = 12;
    localparam int I_VCC_RESTART = 13;
    localparam int I_VCC_5V = 14;
    localparam int I_VCC_ON = 15;
    localparam int I_VCC_HYST = 16;
    localparam int I_PFC_HOT = 17;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam int CTRL_MODE_BIT = 0;
    localparam logic CTRL_MODE_RESET = 1'b0;
    localparam int STAT_RUN_LSB = 0;
    localparam int STAT_OCP_LSB = 3;
    localparam int STAT_OVP_LSB = 5;
    localparam int STAT_PFC_BIT = 8;
    localparam int STAT_SS_BIT = 9;
    localparam int STAT_OVL_BIT = 10;
    localparam int STAT_STARTUP_BIT = 11;

    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_STOP = 3'b001,
        ST_SS_OFF = 3'b010,
        ST_OVP_OFF = 3'b011,
        ST_LATCHED = 3'b100
    } run_state_t;

    typedef enum logic [1:0] {
        OCP_IDLE = 2'b00,
        OCP_WARN = 2'b01,
        OCP_TRIP = 2'b10
    } ocp_state_t;
endpackage

// >>> core/prot_sequencer.sv
/*
 * Protection sequencer: overcurrent hiccup, companion supply switch,
 * latched disable, soft-start overload, overvoltage counting, APB registers.
 * Assumes ARST_N is the undervoltage lockout, low while supply is too low.
 */
`timescale 1ns/100ps
`default_nettype none
module prot_sequencer (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic CE,
    input wire logic [prot_pkg::NIN-1:0] COMP_IN,
    input wire logic OSC_CYCLE,
    input wire logic GATE_OFF,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic SWITCH_EN,
    output logic PFC_SUPPLY_ON,
    output logic UVLO_LOW_SEL,
    output logic RAMP_MAIN_ON,
    output logic RAMP_REDUCED_ON,
    output logic SS_CLAMP_ON,
    output logic FF_SOURCE_ON,
    output logic LOW_POWER,
    output logic STARTUP_EN
);
    import prot_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        run_state_t run;
        ocp_state_t ocp;
        logic warn_armed;
        logic ss_done;
        logic overload;
        logic pfc_open;
        logic [7:0] off_timer;
        logic ovp_timing;
        logic ovp_hit;
        logic [2:0] ovp_cnt;
        logic startup_on;
        logic startup_hold;
        logic mode_ff;
    } prot_state_t;

    prot_state_t r_reg, r_next;
    logic [NIN-1:0] cin;
    logic comp_below;
    logic pfc_level;
    logic qual_ok;
    logic pfc_go;
    logic running;
    logic ovp_window;
    logic ovp_now;
    logic wr_en;

    function automatic logic is_mapped(input logic [7:0] a);
        if (a == ADDR_CTRL) begin
            is_mapped = 1'b1;
        end else if (a == ADDR_STATUS) begin
            is_mapped = 1'b1;
        end else begin
            is_mapped = 1'b0;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Input conditioning

    sig_sync #(
        .W(NIN)
    ) sig_sync_inst (
        .clk(CLK),
        .arst_n(ARST_N),
        .ce(CE),
        .d(COMP_IN),
        .q(cin)
    );

    assign running = (r_reg.run == ST_RUN);

    // Off threshold follows the operating mode
    assign comp_below = r_reg.mode_ff ? cin[I_OFF_FF] : cin[I_OFF_QR];

    // Nothing acting on the control voltage before the ramp has settled
    assign pfc_level = running && r_reg.ss_done && comp_below;

    cycle_qualifier cycle_qualifier_inst (
        .clk(CLK),
        .arst_n(ARST_N),
        .ce(CE),
        .tick(OSC_CYCLE),
        .level(pfc_level),
        .ok(qual_ok)
    );

    // Burst entry opens the switch without waiting
    assign pfc_go = qual_ok || (running && r_reg.ss_done && cin[I_BURST]);

    // Sampling window keeps the turn-off spike away from the comparator
    assign ovp_window = r_reg.ovp_timing && (r_reg.off_timer >= OVP_START)
        && (r_reg.off_timer < OVP_END);
    assign ovp_now = r_reg.ovp_hit || (ovp_window && cin[I_OVP]);

    assign wr_en = PSEL && PENABLE && PWRITE && (PADDR == ADDR_CTRL);

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        r_next = r_reg;

        if (wr_en) begin
            r_next.mode_ff = PWDATA[CTRL_MODE_BIT];
        end

        // Soft-start ramp and open-loop overload
        if (running && cin[I_SS_2V]) begin
            r_next.ss_done = 1'b1;
        end
        // Registered so the ramp currents never glitch
        r_next.overload = running && r_reg.ss_done && cin[I_SAT];

        // Companion supply switch; a new opening beats a close in the same cycle
        if (pfc_go) begin
            r_next.pfc_open = 1'b1;
        end else if (cin[I_COMP_ON]) begin
            r_next.pfc_open = 1'b0;
        end

        // Turn-off timer for the overvoltage window
        if (GATE_OFF) begin
            r_next.off_timer = '0;
            r_next.ovp_timing = 1'b1;
        end else if (r_reg.ovp_timing && r_reg.off_timer != OVP_END) begin
            r_next.off_timer = r_reg.off_timer + 8'h01;
        end else begin
            r_next.ovp_timing = 1'b0;
        end
        r_next.ovp_hit = ovp_now;

        // Per switching cycle: count trips, reset on a quiet cycle
        if (OSC_CYCLE) begin
            r_next.ovp_hit = 1'b0;
            if (ovp_now) begin
                if (r_reg.ovp_cnt != OVP_LAST_COUNT + 3'h1) begin
                    r_next.ovp_cnt = r_reg.ovp_cnt + 3'h1;
                end
            end else begin
                r_next.ovp_cnt = '0;
            end
        end

        // Severe overcurrent watch
        case (r_reg.ocp)
            OCP_IDLE: begin
                r_next.warn_armed = 1'b0;
                if (running && cin[I_SEVERE]) begin
                    r_next.ocp = OCP_WARN;
                end
            end
            OCP_WARN: begin
                // The cycle of the first trip does not count; this is why
                // a stop can come only at a detection in the following cycle
                if (OSC_CYCLE) begin
                    if (!r_reg.warn_armed) begin
                        r_next.warn_armed = 1'b1;
                    end else begin
                        r_next.ocp = OCP_IDLE;
                    end
                end
                if (r_reg.warn_armed && cin[I_SEVERE]) begin
                    r_next.ocp = OCP_TRIP;
                end
            end
            OCP_TRIP: begin
                r_next.ocp = OCP_TRIP;
            end
            default: begin
                r_next.ocp = OCP_IDLE;
            end
        endcase

        // Device state
        case (r_reg.run)
            ST_RUN: begin
                if (cin[I_DIS]) begin
                    r_next.run = ST_LATCHED;
                end else if (r_reg.overload && cin[I_SS_LATCH]) begin
                    r_next.run = ST_LATCHED;
                end else if (r_reg.ocp == OCP_TRIP || cin[I_PFC_HOT]) begin
                    r_next.run = ST_STOP;
                end else if (r_reg.ovp_cnt == OVP_LAST_COUNT && OSC_CYCLE && ovp_now) begin
                    r_next.run = ST_OVP_OFF;
                end else if (r_reg.overload && cin[I_SS_5V]) begin
                    r_next.run = ST_SS_OFF;
                end
            end
            ST_OVP_OFF: begin
                if (cin[I_DIS] || cin[I_VFF_LATCH]) begin
                    r_next.run = ST_LATCHED;
                end else if (cin[I_VCC_5V]) begin
                    // Restart from a clean soft-start
                    r_next.run = ST_RUN;
                    r_next.ss_done = 1'b0;
                    r_next.ovp_cnt = '0;
                    r_next.pfc_open = 1'b0;
                end
            end
            ST_SS_OFF: begin
                if (cin[I_DIS] || cin[I_SS_LATCH]) begin
                    r_next.run = ST_LATCHED;
                end
            end
            ST_STOP: begin
                r_next.run = ST_STOP;
            end
            ST_LATCHED: begin
                r_next.run = ST_LATCHED;
            end
            default: begin
                r_next.run = ST_STOP;
            end
        endcase

        // Startup generator; the hold is set at reset and by mains fail while latched
        if (r_reg.run == ST_LATCHED && cin[I_MAINS_FAIL]) begin
            r_next.startup_hold = 1'b1;
        end else if (cin[I_VCC_RESTART]) begin
            r_next.startup_hold = 1'b0;
        end

        if (r_reg.startup_hold || r_reg.run == ST_STOP) begin
            // Hiccup: no charge until the lockout has cleared the stop
            r_next.startup_on = 1'b0;
        end else if (r_reg.run == ST_LATCHED) begin
            // Pulsed so the dissipation stays low while the latch is fed
            if (cin[I_VCC_HYST]) begin
                r_next.startup_on = 1'b1;
            end else if (cin[I_VCC_ON]) begin
                r_next.startup_on = 1'b0;
            end
        end else begin
            r_next.startup_on = !cin[I_VCC_ON];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // Lockout clears every latch and counter except the startup hold, which it sets
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            r_reg <= '{
                run: ST_RUN,
                ocp: OCP_IDLE,
                warn_armed: 1'b0,
                ss_done: 1'b0,
                overload: 1'b0,
                pfc_open: 1'b0,
                off_timer: 8'h00,
                ovp_timing: 1'b0,
                ovp_hit: 1'b0,
                ovp_cnt: 3'h0,
                startup_on: 1'b0,
                startup_hold: 1'b1,
                mode_ff: CTRL_MODE_RESET
            };
        end else if (CE) begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign SWITCH_EN = running && (r_reg.ocp != OCP_TRIP);
    assign PFC_SUPPLY_ON = running && !r_reg.pfc_open;
    assign UVLO_LOW_SEL = running && r_reg.ss_done && comp_below;
    assign RAMP_MAIN_ON = running;
    assign RAMP_REDUCED_ON = running && r_reg.overload;
    assign SS_CLAMP_ON = !r_reg.overload;
    assign FF_SOURCE_ON = (r_reg.run == ST_OVP_OFF);
    assign LOW_POWER = (r_reg.run == ST_LATCHED);
    assign STARTUP_EN = r_reg.startup_on;

    // Zero-wait slave; CE low drops a write, so software should write while running
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !is_mapped(PADDR);

    always_comb begin
        PRDATA = 32'h0000_0000;
        if (PADDR == ADDR_CTRL) begin
            PRDATA[CTRL_MODE_BIT] = r_reg.mode_ff;
        end else if (PADDR == ADDR_STATUS) begin
            PRDATA[STAT_RUN_LSB +: 3] = r_reg.run;
            PRDATA[STAT_OCP_LSB +: 2] = r_reg.ocp;
            PRDATA[STAT_OVP_LSB +: 3] = r_reg.ovp_cnt;
            PRDATA[STAT_PFC_BIT] = r_reg.pfc_open;
            PRDATA[STAT_SS_BIT] = r_reg.ss_done;
            PRDATA[STAT_OVL_BIT] = r_reg.overload;
            PRDATA[STAT_STARTUP_BIT] = r_reg.startup_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    sequence s_first_trip;
        CE && running && r_reg.ocp == OCP_IDLE && cin[I_SEVERE];
    endsequence

    sequence s_retrip;
        CE && r_reg.ocp == OCP_WARN && r_reg.warn_armed && cin[I_SEVERE];
    endsequence

    sequence s_stopped;
        r_reg.ocp == OCP_TRIP ##1 !SWITCH_EN;
    endsequence

    property p_ocp_warn;
        s_first_trip |=> r_reg.ocp == OCP_WARN && SWITCH_EN;
    endproperty
    a_ocp_warn: assert property (p_ocp_warn) else $error("first trip not warned");

    property p_ocp_stop;
        s_retrip ##1 (CE && running && !cin[I_DIS] && !cin[I_PFC_HOT]) |=> s_stopped;
    endproperty
    a_ocp_stop: assert property (p_ocp_stop) else $error("retrip did not stop");

    property p_stop_held;
        r_reg.run == ST_STOP |=> r_reg.run == ST_STOP && !STARTUP_EN;
    endproperty
    a_stop_held: assert property (p_stop_held) else $error("stop released");

    property p_pfc_open_cause;
        $rose(r_reg.pfc_open) |-> $past(pfc_go) && $past(r_reg.ss_done);
    endproperty
    a_pfc_open_cause: assert property (p_pfc_open_cause) else $error("switch opened early");

    property p_pfc_close_cause;
        $fell(r_reg.pfc_open) && $past(running) |-> $past(cin[I_COMP_ON]);
    endproperty
    a_pfc_close_cause: assert property (p_pfc_close_cause) else $error("switch closed low");

    property p_disable;
        CE && running && cin[I_DIS] |=> LOW_POWER && !SWITCH_EN [*2];
    endproperty
    a_disable: assert property (p_disable) else $error("disable not latched");

    property p_ss_gate;
        !r_reg.ss_done |-> !UVLO_LOW_SEL && !pfc_go && !RAMP_REDUCED_ON;
    endproperty
    a_ss_gate: assert property (p_ss_gate) else $error("ramp gate open");

    property p_ovp_four;
        $rose(FF_SOURCE_ON) && $past(running) |-> $past(r_reg.ovp_cnt) == OVP_LAST_COUNT;
    endproperty
    a_ovp_four: assert property (p_ovp_four) else $error("overvoltage count wrong");

    property p_window;
        r_reg.ovp_hit |-> $past(ovp_window) || $past(r_reg.ovp_hit);
    endproperty
    a_window: assert property (p_window) else $error("sample outside window");
endmodule // prot_sequencer
`default_nettype wire

// >>> core/sig_sync.sv
/*
 * Two-stage synchroniser bank for the comparator results.
 * Assumes the comparators may change at any time relative to the clock.
 */
`timescale 1ns/100ps
`default_nettype none
module sig_sync #(
    parameter int W = prot_pkg::NIN
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    import prot_pkg::*;

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_t;

    sync_state_t s_reg, s_next;

    // First stage feeds only the second stage
    always_comb begin
        s_next = s_reg;
        s_next.meta = d;
        s_next.stable = s_reg.meta;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.stable;
endmodule // sig_sync
`default_nettype wire

// >>> verification/far_side_model.sv
/*
 * Far-side model: oscillator and turn-off pulses plus the comparator bank.
 * Assumes the bench sets the comparator levels and picks the oscillator period.
 */
`timescale 1ns/100ps
`default_nettype none
module far_side_model (
    input wire logic clk,
    input wire logic [7:0] period,
    input wire logic [prot_pkg::NIN-1:0] levels,
    input wire logic ovp_in_win,
    input wire logic ovp_early,
    output logic osc_cycle,
    output logic gate_off,
    output logic [prot_pkg::NIN-1:0] comp
);
    import prot_pkg::*;
    logic [7:0] tmr;
    initial tmr = 8'h00;
    ////////////////////////////////////////
    // Free-running oscillator; the period may change between tests
    always @(posedge clk) begin
        tmr <= (tmr >= period - 8'h01) ? 8'h00 : tmr + 8'h01;
    end
    assign osc_cycle = (tmr == 8'h00);
    assign gate_off = (tmr == 8'h05);
    ////////////////////////////////////////
    // Trips land mid-window or well before it, never on its edges
    always_comb begin
        comp = levels;
        comp[I_OVP] = levels[I_OVP] | (ovp_in_win && tmr >= 8'h5A && tmr <= 8'h60)
            | (ovp_early && tmr >= 8'h14 && tmr <= 8'h28);
    end
endmodule // far_side_model
`default_nettype wire

// >>> verification/prot_sequencer_bench.sv
/*
 * Self-checking bench of the protection sequencer: APB tasks, comparator scenarios.
 * Assumes the far-side model supplies oscillator pulses and comparator levels.
 */
`timescale 1ns/100ps
`default_nettype none
module prot_sequencer_bench;
    import prot_pkg::*;
    logic clk, arst_n, ce, psel, penable, pwrite, in_win, early, err;
    logic [7:0] paddr, period;
    logic [31:0] pwdata, rd;
    logic [NIN-1:0] lv;
    wire pready, pslverr, osc_cycle, gate_off;
    wire [31:0] prdata;
    wire [NIN-1:0] comp;
    // Bit 0 up: switch, pfc supply, uvlo low, ramp main, ramp reduced, clamp, ff, low power, startup
    wire [8:0] outs;
    int mismatches, checks_done;

    prot_sequencer prot_sequencer_inst (
        .CLK(clk), .ARST_N(arst_n), .CE(ce), .COMP_IN(comp), .OSC_CYCLE(osc_cycle),
        .GATE_OFF(gate_off), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SWITCH_EN(outs[0]), .PFC_SUPPLY_ON(outs[1]), .UVLO_LOW_SEL(outs[2]),
        .RAMP_MAIN_ON(outs[3]), .RAMP_REDUCED_ON(outs[4]), .SS_CLAMP_ON(outs[5]),
        .FF_SOURCE_ON(outs[6]), .LOW_POWER(outs[7]), .STARTUP_EN(outs[8]));
    far_side_model far_side_model_inst (
        .clk(clk), .period(period), .levels(lv), .ovp_in_win(in_win), .ovp_early(early),
        .osc_cycle(osc_cycle), .gate_off(gate_off), .comp(comp));
    ////////////////////////////////////////
    task automatic wrap_up();
        $display("Mismatches %0d, checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // A wait that ran out of its bound ends the run
    task automatic bail(input logic ok);
        if (ok !== 1'b1) begin
            mismatches++;
            $display("FAIL at %0t: wait ran out", $time);
            wrap_up();
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        bail(pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic run_is(input logic [2:0] r);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd[STAT_RUN_LSB +: 3], r);
    endtask
    task automatic set_lv(input int i, input logic v);
        lv[i] <= v;
        repeat (6) @(posedge clk);
    endtask
    task automatic wait_osc(input int n);
        int k;
        repeat (n) begin
            k = 0;
            do begin
                @(posedge clk);
                k++;
            end while (osc_cycle !== 1'b1 && k < 300);
            bail(osc_cycle);
        end
    endtask
    // Short mid-run lockout; levels drop so every test starts from a known point
    task automatic rst();
        arst_n <= 1'b0;
        lv <= '0;
        period <= 8'h78;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
    endtask
    task automatic trips(input int n);
        in_win <= 1'b1;
        wait_osc(n);
        in_win <= 1'b0;
    endtask
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        arst_n = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        lv = '0;
        period = 8'h78;
        in_win = 1'b0;
        early = 1'b0;
        mismatches = 0;
        checks_done = 0;
        repeat (11) @(posedge clk);
        check(outs, 9'h02B);
        @(posedge clk);
        arst_n <= 1'b1;
        apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        check({err, rd[30:0]}, 32'h8000_0000);
        check(outs[8], 1'b0);
        set_lv(I_VCC_RESTART, 1'b1);
        set_lv(I_VCC_RESTART, 1'b0);
        check(outs[8], 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd, 32'h1);
        set_lv(I_OFF_FF, 1'b1);
        check(outs[2], 1'b0);
        set_lv(I_OFF_FF, 1'b0);
        set_lv(I_SS_2V, 1'b1);
        set_lv(I_OFF_QR, 1'b1);
        check(outs[2], 1'b0);
        set_lv(I_OFF_FF, 1'b1);
        check(outs[2], 1'b1);
        period <= 8'h14;
        wait_osc(600);
        set_lv(I_OFF_FF, 1'b0);
        set_lv(I_OFF_FF, 1'b1);
        wait_osc(1000);
        check(outs[1], 1'b1);
        wait_osc(30);
        check(outs[1], 1'b0);
        set_lv(I_OFF_FF, 1'b0);
        check(outs[1], 1'b0);
        set_lv(I_COMP_ON, 1'b1);
        check(outs[1], 1'b1);
        rst();
        // Trip just after a cycle start, so one pulse never spans a cycle boundary
        wait_osc(1);
        set_lv(I_SEVERE, 1'b1);
        set_lv(I_SEVERE, 1'b0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd[4:0], 5'h08);
        wait_osc(3);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd[4:0], 5'h00);
        set_lv(I_SEVERE, 1'b1);
        set_lv(I_SEVERE, 1'b0);
        wait_osc(1);
        set_lv(I_SEVERE, 1'b1);
        set_lv(I_SEVERE, 1'b0);
        check(outs[0], 1'b0);
        run_is(3'h1);
        wait_osc(4);
        run_is(3'h1);
        rst();
        run_is(3'h0);
        // Enable low freezes the synchroniser, so the disable is not seen yet
        ce <= 1'b0;
        set_lv(I_DIS, 1'b1);
        run_is(3'h0);
        ce <= 1'b1;
        set_lv(I_DIS, 1'b1);
        set_lv(I_DIS, 1'b0);
        run_is(3'h4);
        check({outs[7], outs[0]}, 2'b10);
        // Lockout left the startup hold set; supply below restart clears it
        set_lv(I_VCC_RESTART, 1'b1);
        set_lv(I_VCC_RESTART, 1'b0);
        set_lv(I_VCC_HYST, 1'b1);
        check(outs[8], 1'b1);
        set_lv(I_VCC_HYST, 1'b0);
        set_lv(I_VCC_ON, 1'b1);
        check(outs[8], 1'b0);
        set_lv(I_VCC_ON, 1'b0);
        set_lv(I_MAINS_FAIL, 1'b1);
        set_lv(I_VCC_HYST, 1'b1);
        check(outs[8], 1'b0);
        rst();
        set_lv(I_SS_2V, 1'b1);
        set_lv(I_SAT, 1'b1);
        check({outs[5], outs[4]}, 2'b01);
        set_lv(I_SAT, 1'b0);
        check({outs[5], outs[4]}, 2'b10);
        set_lv(I_SAT, 1'b1);
        set_lv(I_SS_5V, 1'b1);
        run_is(3'h2);
        rst();
        set_lv(I_SS_2V, 1'b1);
        set_lv(I_SAT, 1'b1);
        set_lv(I_SS_LATCH, 1'b1);
        run_is(3'h4);
        rst();
        set_lv(I_SS_2V, 1'b1);
        set_lv(I_OFF_QR, 1'b1);
        check(outs[2], 1'b1);
        set_lv(I_PFC_HOT, 1'b1);
        run_is(3'h1);
        rst();
        set_lv(I_SS_2V, 1'b1);
        early <= 1'b1;
        wait_osc(6);
        early <= 1'b0;
        run_is(3'h0);
        trips(3);
        wait_osc(1);
        trips(3);
        run_is(3'h0);
        trips(1);
        run_is(3'h3);
        check({outs[6], outs[0]}, 2'b10);
        set_lv(I_VCC_5V, 1'b1);
        run_is(3'h0);
        set_lv(I_VCC_5V, 1'b0);
        wait_osc(1);
        trips(4);
        set_lv(I_VFF_LATCH, 1'b1);
        run_is(3'h4);
        wrap_up();
    end
endmodule // prot_sequencer_bench
`default_nettype wire
